// ===== logic/mat_pkg.sv
// constants and types for the operand addressing and cycle timing sequencer
package mat_pkg;

    // ****************************************************************
    // memory spaces and access kinds
    // ****************************************************************
    typedef enum logic [2:0]
    {
        SP_NONE,
        SP_IRAM,
        SP_SFR,
        SP_EXTENDED_RAM,
        SP_CODE
    } mat_space_e;

    typedef enum logic [1:0]
    {
        AK_NONE,
        AK_XRD,
        AK_XWR,
        AK_CODE
    } mat_access_e;

    // ****************************************************************
    // address map and sizes
    // ****************************************************************
    localparam int          EXTENDED_RAM_DEPTH    = 256;
    localparam int          EXTENDED_RAM_AW       = 8;
    localparam logic [7:0]  UPPER_HALF    = 8'h80;

    // ****************************************************************
    // opcodes and low-nibble operand forms
    // ****************************************************************
    localparam logic [7:0]  OP_INC_DATA_POINTER   = 8'ha3;
    localparam logic [7:0]  OP_MUL        = 8'ha4;
    localparam logic [7:0]  OP_DIV        = 8'h84;
    localparam logic [7:0]  OP_XRD_DATA_POINTER   = 8'he0;
    localparam logic [7:0]  OP_XWR_DATA_POINTER   = 8'hf0;
    localparam logic [6:0]  OP_XRD_RI     = 7'h71;
    localparam logic [6:0]  OP_XWR_RI     = 7'h79;
    localparam logic [7:0]  OP_CODE_DATA_POINTER  = 8'h93;
    localparam logic [7:0]  OP_CODE_PC    = 8'h83;
    localparam logic [3:0]  HI_INC        = 4'h0;
    localparam logic [3:0]  HI_DEC        = 4'h1;
    localparam logic [3:0]  HI_ADD        = 4'h2;
    localparam logic [3:0]  HI_ADD_WITH_CARRY       = 4'h3;
    localparam logic [3:0]  HI_OR         = 4'h4;
    localparam logic [3:0]  HI_AND        = 4'h5;
    localparam logic [3:0]  HI_XOR        = 4'h6;
    localparam logic [3:0]  HI_SUBTRACT_WITH_BORROW       = 4'h9;
    localparam logic [3:0]  LO_DIR_ACC    = 4'h2;
    localparam logic [3:0]  LO_DIR_IMM    = 4'h3;
    localparam logic [3:0]  LO_IMM        = 4'h4;
    localparam logic [3:0]  LO_DIR        = 4'h5;

    // ****************************************************************
    // byte and cycle counts
    // ****************************************************************
    localparam logic [1:0]  BYTES_1       = 2'd1;
    localparam logic [1:0]  BYTES_2       = 2'd2;
    localparam logic [1:0]  BYTES_3       = 2'd3;
    localparam logic [3:0]  CYC_1         = 4'd1;
    localparam logic [3:0]  CYC_2         = 4'd2;
    localparam logic [3:0]  CYC_3         = 4'd3;
    localparam logic [3:0]  CYC_EXT       = 4'd4;
    localparam logic [3:0]  CYC_MULDIV    = 4'd9;
    localparam logic [3:0]  CNT_RESET     = 4'd0;
    localparam logic [3:0]  CNT_MEM_ISSUE = 4'd1;
    localparam logic [3:0]  CNT_MEM_TAKE  = 4'd2;

endpackage : mat_pkg

// ===== logic/mat_extended_ram.sv
// 256 x 8 extended RAM with registered read data
`timescale 1ns/1ps
module mat_extended_ram
(
    input  wire logic                         i_clk,
    input  wire logic                         i_we,
    input  wire logic [mat_pkg::EXTENDED_RAM_AW-1:0]  i_addr,
    input  wire logic [7:0]                   i_wdata,
    output logic      [7:0]                   o_rdata
);

    logic [7:0] mem_q [mat_pkg::EXTENDED_RAM_DEPTH];
    logic [7:0] rdata_q;

    // write port and registered read port
    always_ff @(posedge i_clk)
    begin
        if (i_we)
        begin
            mem_q[i_addr] <= i_wdata;
        end
        rdata_q <= mem_q[i_addr];
    end

    assign o_rdata = rdata_q;

endmodule : mat_extended_ram

// ===== logic/mat_sequencer.sv
// operand addressing decode, extended RAM and per-instruction cycle sequencer
`timescale 1ns/1ps
module mat_sequencer
(
    input  wire logic                 i_clk,
    input  wire logic                 i_nrst,
    input  wire logic                 i_start,
    input  wire logic [7:0]           i_opcode,
    input  wire logic [7:0]           i_dir_addr,
    input  wire logic [7:0]           i_acc,
    input  wire logic [15:0]          i_data_pointer,
    input  wire logic [7:0]           i_pointer_work_reg,
    input  wire logic [15:0]          i_pc,
    input  wire logic [7:0]           i_code_data,
    output mat_pkg::mat_space_e       o_space,
    output logic      [15:0]          o_mem_addr,
    output logic      [1:0]           o_instr_bytes,
    output logic      [3:0]           o_instr_cycles,
    output logic      [3:0]           o_cycle_cnt,
    output logic                      o_busy,
    output logic                      o_done,
    output logic                      o_unknown,
    output logic                      o_code_rd,
    output logic      [15:0]          o_code_addr,
    output logic      [7:0]           o_rd_data,
    output logic                      o_ext_bus_req
);

    // ****************************************************************
    // decode of the presented opcode
    // ****************************************************************
    mat_pkg::mat_space_e  dec_space;
    mat_pkg::mat_access_e dec_access;
    logic [15:0]          dec_addr;
    logic [1:0]           dec_bytes;
    logic [3:0]           dec_cycles;
    logic                 dec_unknown;
    logic                 dec_indirect;
    logic [3:0]           hi;
    logic [3:0]           lo;

    assign hi = i_opcode[7:4];
    assign lo = i_opcode[3:0];

    // classify opcode into bytes, cycles, memory space and address
    always_comb
    begin
        dec_space    = mat_pkg::SP_NONE;
        dec_access   = mat_pkg::AK_NONE;
        dec_addr     = 16'h0000;
        dec_bytes    = mat_pkg::BYTES_1;
        dec_cycles   = mat_pkg::CYC_1;
        dec_unknown  = 1'b0;
        dec_indirect = 1'b0;
        if (i_opcode == mat_pkg::OP_MUL || i_opcode == mat_pkg::OP_DIV)
        begin
            dec_cycles = mat_pkg::CYC_MULDIV;
        end
        else if (i_opcode == mat_pkg::OP_INC_DATA_POINTER)
        begin
            dec_cycles = mat_pkg::CYC_3;
        end
        else if (i_opcode == mat_pkg::OP_XRD_DATA_POINTER || i_opcode == mat_pkg::OP_XWR_DATA_POINTER)
        begin
            dec_space  = mat_pkg::SP_EXTENDED_RAM;
            dec_access = (i_opcode == mat_pkg::OP_XRD_DATA_POINTER) ? mat_pkg::AK_XRD : mat_pkg::AK_XWR;
            dec_addr   = {8'h00, i_data_pointer[7:0]};
            dec_cycles = mat_pkg::CYC_EXT;
        end
        else if (i_opcode[7:1] == mat_pkg::OP_XRD_RI || i_opcode[7:1] == mat_pkg::OP_XWR_RI)
        begin
            dec_space  = mat_pkg::SP_EXTENDED_RAM;
            dec_access = (i_opcode[7:1] == mat_pkg::OP_XRD_RI) ? mat_pkg::AK_XRD
                                                                : mat_pkg::AK_XWR;
            dec_addr   = {8'h00, i_pointer_work_reg};
            dec_cycles = mat_pkg::CYC_EXT;
        end
        else if (i_opcode == mat_pkg::OP_CODE_DATA_POINTER || i_opcode == mat_pkg::OP_CODE_PC)
        begin
            dec_space  = mat_pkg::SP_CODE;
            dec_access = mat_pkg::AK_CODE;
            dec_addr   = ((i_opcode == mat_pkg::OP_CODE_DATA_POINTER) ? i_data_pointer : i_pc)
                         + {8'h00, i_acc};
            dec_cycles = mat_pkg::CYC_EXT;
        end
        else if (hi == mat_pkg::HI_INC || hi == mat_pkg::HI_DEC || hi == mat_pkg::HI_ADD
                 || hi == mat_pkg::HI_ADD_WITH_CARRY || hi == mat_pkg::HI_SUBTRACT_WITH_BORROW
                 || hi == mat_pkg::HI_OR || hi == mat_pkg::HI_AND || hi == mat_pkg::HI_XOR)
        begin
            if (lo[3])
            begin
                // register operand lives in the internal RAM register bank
                dec_space  = mat_pkg::SP_IRAM;
                dec_cycles = mat_pkg::CYC_1;
            end
            else if (lo[3:1] == 3'b011)
            begin
                dec_space    = mat_pkg::SP_IRAM;
                dec_addr     = {8'h00, i_pointer_work_reg};
                dec_indirect = 1'b1;
                dec_cycles   = mat_pkg::CYC_2;
            end
            else if (lo == mat_pkg::LO_DIR)
            begin
                dec_space  = (i_dir_addr >= mat_pkg::UPPER_HALF) ? mat_pkg::SP_SFR
                                                                  : mat_pkg::SP_IRAM;
                dec_addr   = {8'h00, i_dir_addr};
                dec_bytes  = mat_pkg::BYTES_2;
                dec_cycles = mat_pkg::CYC_2;
            end
            else if (lo == mat_pkg::LO_IMM)
            begin
                // inc and dec use this slot for the accumulator form
                if (hi == mat_pkg::HI_INC || hi == mat_pkg::HI_DEC)
                begin
                    dec_cycles = mat_pkg::CYC_1;
                end
                else
                begin
                    dec_bytes  = mat_pkg::BYTES_2;
                    dec_cycles = mat_pkg::CYC_2;
                end
            end
            else if ((lo == mat_pkg::LO_DIR_ACC || lo == mat_pkg::LO_DIR_IMM)
                     && (hi == mat_pkg::HI_OR || hi == mat_pkg::HI_AND || hi == mat_pkg::HI_XOR))
            begin
                dec_space  = (i_dir_addr >= mat_pkg::UPPER_HALF) ? mat_pkg::SP_SFR
                                                                  : mat_pkg::SP_IRAM;
                dec_addr   = {8'h00, i_dir_addr};
                dec_bytes  = (lo == mat_pkg::LO_DIR_IMM) ? mat_pkg::BYTES_3 : mat_pkg::BYTES_2;
                dec_cycles = (lo == mat_pkg::LO_DIR_IMM) ? mat_pkg::CYC_3
                                                         : mat_pkg::CYC_2;
            end
            else
            begin
                dec_unknown = 1'b1;
            end
        end
        else
        begin
            dec_unknown = 1'b1;
        end
    end

    // ****************************************************************
    // cycle sequencer
    // ****************************************************************
    mat_pkg::mat_space_e  space_q, space_d;
    mat_pkg::mat_access_e access_q, access_d;
    logic [15:0]          addr_q, addr_d;
    logic [1:0]           bytes_q, bytes_d;
    logic [3:0]           cycles_q, cycles_d;
    logic [3:0]           cnt_q, cnt_d;
    logic                 busy_q, busy_d;
    logic                 done_q, done_d;
    logic                 unk_q, unk_d;
    logic                 ind_q, ind_d;
    logic                 code_rd_q, code_rd_d;
    logic [7:0]           wdata_q, wdata_d;
    logic [7:0]           rd_q, rd_d;
    logic                 accept;
    logic [7:0]           extended_ram_rdata;
    logic                 extended_ram_we;

    assign accept = i_start && (!busy_q || done_q);

    // next state: load on accept, count while busy, pulse done on the last cycle
    always_comb
    begin
        space_d   = space_q;
        access_d  = access_q;
        addr_d    = addr_q;
        bytes_d   = bytes_q;
        cycles_d  = cycles_q;
        unk_d     = unk_q;
        ind_d     = ind_q;
        wdata_d   = wdata_q;
        rd_d      = rd_q;
        cnt_d     = cnt_q;
        busy_d    = busy_q;
        done_d    = 1'b0;
        code_rd_d = 1'b0;
        if (accept)
        begin
            space_d   = dec_space;
            access_d  = dec_access;
            addr_d    = dec_addr;
            bytes_d   = dec_bytes;
            cycles_d  = dec_cycles;
            unk_d     = dec_unknown;
            ind_d     = dec_indirect;
            wdata_d   = i_acc;
            cnt_d     = mat_pkg::CNT_MEM_ISSUE;
            busy_d    = 1'b1;
            done_d    = (dec_cycles == mat_pkg::CYC_1);
            code_rd_d = (dec_access == mat_pkg::AK_CODE);
        end
        else if (busy_q && done_q)
        begin
            busy_d = 1'b0;
            cnt_d  = mat_pkg::CNT_RESET;
        end
        else if (busy_q)
        begin
            cnt_d  = cnt_q + 4'd1;
            done_d = ((cnt_q + 4'd1) == cycles_q);
            if (cnt_q == mat_pkg::CNT_MEM_TAKE)
            begin
                rd_d = (access_q == mat_pkg::AK_CODE) ? i_code_data : extended_ram_rdata;
            end
        end
    end

    // registers of the sequencer
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            space_q   <= mat_pkg::SP_NONE;
            access_q  <= mat_pkg::AK_NONE;
            addr_q    <= 16'h0000;
            bytes_q   <= 2'd0;
            cycles_q  <= mat_pkg::CNT_RESET;
            cnt_q     <= mat_pkg::CNT_RESET;
            busy_q    <= 1'b0;
            done_q    <= 1'b0;
            unk_q     <= 1'b0;
            ind_q     <= 1'b0;
            code_rd_q <= 1'b0;
            wdata_q   <= 8'h00;
            rd_q      <= 8'h00;
        end
        else
        begin
            space_q   <= space_d;
            access_q  <= access_d;
            addr_q    <= addr_d;
            bytes_q   <= bytes_d;
            cycles_q  <= cycles_d;
            cnt_q     <= cnt_d;
            busy_q    <= busy_d;
            done_q    <= done_d;
            unk_q     <= unk_d;
            ind_q     <= ind_d;
            code_rd_q <= code_rd_d;
            wdata_q   <= wdata_d;
            rd_q      <= rd_d;
        end
    end

    // ****************************************************************
    // on-chip extended RAM, no external bus
    // ****************************************************************
    assign extended_ram_we = busy_q && (access_q == mat_pkg::AK_XWR)
                     && (cnt_q == mat_pkg::CNT_MEM_ISSUE);

    mat_extended_ram u_extended_ram
    (
        .i_clk   (i_clk),
        .i_we    (extended_ram_we),
        .i_addr  (addr_q[mat_pkg::EXTENDED_RAM_AW-1:0]),
        .i_wdata (wdata_q),
        .o_rdata (extended_ram_rdata)
    );

    // outputs straight from registers, external bus request tied low
    assign o_space        = space_q;
    assign o_mem_addr     = addr_q;
    assign o_instr_bytes  = bytes_q;
    assign o_instr_cycles = cycles_q;
    assign o_cycle_cnt    = cnt_q;
    assign o_busy         = busy_q;
    assign o_done         = done_q;
    assign o_unknown      = unk_q;
    assign o_code_rd      = code_rd_q;
    assign o_code_addr    = addr_q;
    assign o_rd_data      = rd_q;
    assign o_ext_bus_req  = 1'b0;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    a_ind_upper_iram: assert property (o_done && ind_q |-> o_space == mat_pkg::SP_IRAM)
        else $error("indirect operand left internal RAM");
    a_lower_half_iram: assert property (o_done && !o_mem_addr[7]
        && (o_space == mat_pkg::SP_IRAM || o_space == mat_pkg::SP_SFR)
        |-> o_space == mat_pkg::SP_IRAM)
        else $error("lower half address not internal RAM");
    a_sfr_upper_only: assert property (o_done && o_space == mat_pkg::SP_SFR
        |-> o_mem_addr[7] && !ind_q)
        else $error("special register space from wrong address");
    a_ext_bus_idle: assert property (!o_ext_bus_req)
        else $error("external bus cycle generated");
    // counter starts at 1 the cycle after accept, so done is nine ticks later
    a_muldiv_nine: assert property (accept
        && (i_opcode == mat_pkg::OP_MUL || i_opcode == mat_pkg::OP_DIV)
        |=> !o_done [*8] ##1 (o_done && o_cycle_cnt == 4'd9))
        else $error("multiply or divide not nine cycles");
    a_ext_four: assert property (accept && dec_access != mat_pkg::AK_NONE
        |-> ##4 (o_done && o_instr_bytes == 2'd1))
        else $error("extended or code move not four cycles");
    a_ext_addr_data_pointer: assert property (accept && i_opcode == mat_pkg::OP_XRD_DATA_POINTER
        |=> o_mem_addr == {8'h00, $past(i_data_pointer[7:0])})
        else $error("extended direct address wrong");
    a_ext_addr_ri: assert property (accept && i_opcode[7:1] == mat_pkg::OP_XWR_RI
        |=> o_mem_addr == {8'h00, $past(i_pointer_work_reg)}
        && o_space == mat_pkg::SP_EXTENDED_RAM)
        else $error("extended indirect address wrong");
    a_code_index: assert property (accept && i_opcode == mat_pkg::OP_CODE_DATA_POINTER
        |=> o_code_rd && o_code_addr == $past(i_data_pointer) + {8'h00, $past(i_acc)})
        else $error("code read address wrong");
    a_reg_one: assert property (accept && i_opcode[7:4] == mat_pkg::HI_ADD
        && i_opcode[3] |=> o_done && o_cycle_cnt == 4'd1)
        else $error("register add not one cycle");
    a_data_pointer_inc_three: assert property (accept && i_opcode == mat_pkg::OP_INC_DATA_POINTER
        |-> ##3 (o_done && o_cycle_cnt == 4'd3))
        else $error("data pointer increment not three cycles");
    a_logic_dir_imm: assert property (o_done && !o_unknown
        && o_instr_bytes == 2'd3 |-> o_cycle_cnt == 4'd3)
        else $error("immediate-to-direct logic timing wrong");
    a_cnt_matches: assert property (o_done |-> o_cycle_cnt == o_instr_cycles)
        else $error("cycle counter disagrees with cycle count");
    // a write, then a data-pointer read of the same byte accepted right after the write ends
    a_extended_ram_readback: assert property (extended_ram_we ##4 (accept
        && i_opcode == mat_pkg::OP_XRD_DATA_POINTER && i_data_pointer[7:0] == $past(addr_q[7:0], 4))
        |-> ##3 o_rd_data == $past(wdata_q, 7))
        else $error("extended RAM read back wrong");

    c_muldiv: cover property (accept && i_opcode == mat_pkg::OP_MUL ##9 o_done);
    c_extended_ram_write: cover property (extended_ram_we);
    c_code_read: cover property (o_code_rd ##3 o_done);
    c_sfr_access: cover property (o_done && o_space == mat_pkg::SP_SFR);
    c_back_to_back: cover property (o_done && accept);

endmodule : mat_sequencer

// ===== verif/mat_flash_model.sv
// flash program memory model that answers code reads
`timescale 1ns/1ps
module mat_flash_model
(
    input  wire logic        i_clk,
    input  wire logic        i_rd,
    input  wire logic [15:0] i_addr,
    output logic      [7:0]  o_data
);
    initial o_data = 8'h3c;
    // byte valid in the cycle after the read pulse, then inverted on every later cycle until the next read
    always @(posedge i_clk)
    begin
        if (i_rd)
            o_data <= i_addr[15:8] ^ i_addr[7:0] ^ 8'h5a;
        else
            o_data <= ~o_data;
    end
endmodule : mat_flash_model

// ===== verif/mat_sequencer_test.sv
// self-checking testbench for the addressing and cycle sequencer
`timescale 1ns/1ps
module mat_sequencer_test;
    logic                i_clk = 1'b0;
    logic                i_nrst = 1'b0;
    logic                i_start = 1'b0;
    logic [7:0]          i_opcode = 8'h00, i_dir_addr = 8'h00, i_acc = 8'h00;
    logic [7:0]          i_pointer_work_reg = 8'h00;
    logic [15:0]         i_data_pointer = 16'h0000, i_pc = 16'h0000;
    wire logic [7:0]     code_data;
    mat_pkg::mat_space_e o_space;
    logic [15:0]         o_mem_addr, o_code_addr;
    logic [1:0]          o_instr_bytes;
    logic [3:0]          o_instr_cycles, o_cycle_cnt;
    logic                o_busy, o_done, o_unknown, o_code_rd, o_ext_bus_req;
    logic [7:0]          o_rd_data;
    logic [31:0]         rng = 32'd96404, r, q;
    int                  n_errors = 0, total_checks = 0, cycles = 0;

    mat_sequencer mat_sequencer_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_start(i_start),
        .i_opcode(i_opcode), .i_dir_addr(i_dir_addr), .i_acc(i_acc),
        .i_data_pointer(i_data_pointer), .i_pointer_work_reg(i_pointer_work_reg),
        .i_pc(i_pc), .i_code_data(code_data), .o_space(o_space), .o_mem_addr(o_mem_addr),
        .o_instr_bytes(o_instr_bytes), .o_instr_cycles(o_instr_cycles),
        .o_cycle_cnt(o_cycle_cnt), .o_busy(o_busy), .o_done(o_done), .o_unknown(o_unknown),
        .o_code_rd(o_code_rd), .o_code_addr(o_code_addr), .o_rd_data(o_rd_data),
        .o_ext_bus_req(o_ext_bus_req));
    mat_flash_model mat_flash_model_i (.i_clk(i_clk), .i_rd(o_code_rd), .i_addr(o_code_addr),
        .o_data(code_data));

    // ****************************************************************
    // clock, timeout and helpers
    // ****************************************************************
    always #25 i_clk = ~i_clk;
    // cycle ceiling on every cycle and bus-free watch on every cycle out of reset
    always @(posedge i_clk)
    begin
        cycles++;
        if (i_nrst) chk("ext_bus_req", 16'h0, {15'h0, o_ext_bus_req});
        if (cycles > 20000)
        begin
            n_errors++;
            finish_test();
        end
    end
    function logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : rnd
    function bit spec(input logic [7:0] o);
        return o inside {8'ha3, 8'ha4, 8'h84, 8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3,
                         8'h93, 8'h83};
    endfunction : spec
    function bit known(input logic [7:0] o);
        return spec(o) || (o[7:4] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h9} && o[3:0] >= 4'h4)
            || (o[7:4] inside {4'h4, 4'h5, 4'h6} && o[3:0] >= 4'h2);
    endfunction : known
    function logic [3:0] e_cyc(input logic [7:0] o);
        if (o == 8'ha3) return 4'd3;
        if (o == 8'ha4 || o == 8'h84) return 4'd9;
        if (spec(o)) return 4'd4;
        if (!known(o) || o[3:0] >= 4'h8) return 4'd1;
        if (o[3:0] == 4'h4) return (o[7:4] < 4'h2) ? 4'd1 : 4'd2;
        return (o[3:0] == 4'h3) ? 4'd3 : 4'd2;
    endfunction : e_cyc
    function logic [1:0] e_byt(input logic [7:0] o);
        if (spec(o) || o[3:0] >= 4'h6) return 2'd1;
        if (o[3:0] == 4'h4) return (o[7:4] < 4'h2) ? 2'd1 : 2'd2;
        return (o[3:0] == 4'h3) ? 2'd3 : 2'd2;
    endfunction : e_byt
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task chs(input mat_pkg::mat_space_e e);
        chk("space", {13'h0, e}, {13'h0, o_space});
    endtask : chs

    // runs one instruction; chain raises the next start in the done cycle
    task automatic run(input logic [7:0] o, d, a, input logic [15:0] p,
                       input logic [7:0] w, input bit chain);
        int n;
        logic [15:0] ca;
        i_opcode = o; i_dir_addr = d; i_acc = a; i_data_pointer = p;
        i_pointer_work_reg = w; i_pc = ~p; i_start = 1'b1;
        @(posedge i_clk); #2;
        n = 1;
        while (o_done !== 1'b1 && n < 12)
        begin
            chk("busy", 16'h1, {15'h0, o_busy});
            chk("cycle_cnt", n[15:0], {12'h0, o_cycle_cnt});
            i_start = 1'b0;
            @(posedge i_clk); #2;
            n++;
        end
        chk("cycles", {12'h0, e_cyc(o)}, n[15:0]);
        chk("unknown", {15'h0, !known(o)}, {15'h0, o_unknown});
        if (known(o)) chk("instr_cycles", {12'h0, e_cyc(o)}, {12'h0, o_instr_cycles});
        if (known(o)) chk("bytes", {14'h0, e_byt(o)}, {14'h0, o_instr_bytes});
        if (o == 8'h93 || o == 8'h83)
        begin
            ca = ((o == 8'h93) ? p : ~p) + {8'h00, a};
            chs(mat_pkg::SP_CODE);
            chk("code_addr", ca, o_code_addr);
            chk("code_byte", {8'h00, ca[15:8] ^ ca[7:0] ^ 8'h5a}, {8'h00, o_rd_data});
        end
        else if (spec(o) && o[7:5] == 3'b111)
        begin
            chs(mat_pkg::SP_EXTENDED_RAM);
            chk("extended_ram_addr", {8'h00, o[1] ? w : p[7:0]}, o_mem_addr);
        end
        else if (known(o) && !spec(o) && o[3:0] >= 4'h8)
            chs(mat_pkg::SP_IRAM);
        else if (known(o) && !spec(o) && o[3:0] >= 4'h6)
        begin
            chs(mat_pkg::SP_IRAM);
            chk("ind_addr", {8'h00, w}, o_mem_addr);
        end
        else if (known(o) && !spec(o) && o[3:0] != 4'h4)
        begin
            chs(d[7] ? mat_pkg::SP_SFR : mat_pkg::SP_IRAM);
            chk("dir_addr", {8'h00, d}, o_mem_addr);
        end
        if (!chain)
        begin
            i_start = 1'b0;
            @(posedge i_clk); #2;
            chk("idle_busy", 16'h0, {15'h0, o_busy});
            chk("idle_done", 16'h0, {15'h0, o_done});
        end
    endtask : run

    task finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        repeat (6) @(posedge i_clk);
        #2;
        chk("reset_busy", 16'h0, {15'h0, o_busy});
        i_nrst = 1'b1;
        // every opcode, back to back when the random chain bit r[0] is set
        for (int k = 0; k < 256; k++)
        begin
            r = rnd();
            run(k[7:0], r[7:0], r[15:8], r[31:16], r[23:16], r[0]);
        end
        run(8'h25, 8'h7f, 8'h00, 16'h0000, 8'h00, 1'b0);
        run(8'h55, 8'h80, 8'h00, 16'h0000, 8'h00, 1'b1);
        run(8'h66, 8'h00, 8'h00, 16'h0000, 8'h80, 1'b0);
        run(8'h93, 8'h00, 8'h02, 16'hffff, 8'h00, 1'b0);
        $display("test directed opcodes done");
        // extended RAM write and read back through the other pointer form
        repeat (8)
        begin
            r = rnd();
            run(8'hf0, 8'h00, r[7:0], r[31:16], 8'h00, 1'b0);
            run(8'he3, 8'h00, 8'h00, 16'h0000, r[23:16], 1'b0);
            chk("extended_ram_rd", {8'h00, r[7:0]}, {8'h00, o_rd_data});
            run(8'hf2, 8'h00, ~r[7:0], 16'h0000, r[15:8], 1'b0);
            run(8'he0, 8'h00, 8'h00, {r[31:24], r[15:8]}, 8'h00, 1'b0);
            chk("extended_ram_rd2", {8'h00, ~r[7:0]}, {8'h00, o_rd_data});
        end
        $display("test extended ram done");
        // random instruction stream
        repeat (200)
        begin
            r = rnd();
            q = rnd();
            run(q[7:0], r[7:0], r[15:8], r[31:16], q[15:8], q[16]);
        end
        $display("test random stream done");
        finish_test();
    end
endmodule : mat_sequencer_test
